// ---- rtl/redundancy_map.svh ----
// Operation
// - Slave role forces partner input priority to one
// - Slave role forces main phase build-out off; monitor build-out not forced
// - Slave role forces revertive switching on
// - Slave main loop always uses acquisition bandwidth
// - Master role forces nothing; software values apply
// - Role pin level readable, not writable
// - Locked, no build-out: equal-rate outputs aligned
// - Faster outputs falling-edge aligned to reference rate
// - Slower outputs aligned only at integer sub-multiples
// - Same alignment holds for auxiliary loop outputs
`ifndef REDUNDANCY_MAP_SVH
`define REDUNDANCY_MAP_SVH

`define REG_PRI_BASE 8'h00
`define REG_MAIN_CONTROL_THREE 8'h1c
`define REG_MAIN_CONTROL_TEN 8'h20
`define REG_PHASE_MONITOR_REG 8'h24
`define REG_ABW 8'h28
`define REG_LBW 8'h2c
`define REG_STATUS 8'h30
`define REG_RATIO_MAIN 8'h34
`define REG_RATIO_AUX 8'h38

`define PRI_WORDS 7
`define PARTNER_WORD 5
`define FORCED_PRIORITY 4'h1
`define N_OUT 4

`define MAIN_CONTROL_THREE_REVERTIVE_SWITCH_ENABLE_BIT 0
`define MAIN_CONTROL_THREE_ROLE_BIT 1
`define MAIN_CONTROL_TEN_PBO_BIT 0
`define PHASE_MONITOR_REG_PBO_BIT 0

`define PRI_RST 8'h00
`define MAIN_CONTROL_THREE_RST 1'b0
`define MAIN_CONTROL_TEN_RST 1'b1
`define PHASE_MONITOR_REG_RST 1'b1
`define ABW_RST 8'h10
`define LBW_RST 8'h04
`define RATIO_RST 32'h11111111

`endif

// ---- rtl/redundancy_pkg.sv ----
package redundancy_pkg;

   typedef enum logic [1:0] {ALIGN_EQUAL, ALIGN_FALLING, ALIGN_SUBMULT, ALIGN_NONE} align_class_e;

   typedef enum logic {BUS_IDLE, BUS_ANSWER} bus_state_e;

   // Output frequency is reference * mult / div
   typedef struct packed {
      logic [3:0] mult;
      logic [3:0] div;
   } ratio_s;

   typedef struct packed {
      logic [13:0][3:0] prio;
      logic buildout_en;
      logic monitor_buildout_en;
      logic revertive_en;
      logic [7:0] bandwidth;
   } loop_config_s;

   function automatic align_class_e classify(input ratio_s r);
      align_class_e c;
      c = ALIGN_NONE;
      if (r.mult != 4'h0 && r.div != 4'h0) begin
         if (r.mult == r.div) begin
            c = ALIGN_EQUAL;
         end else if (r.mult > r.div) begin
            c = ALIGN_FALLING;
         end else if ((r.div % r.mult) == 4'h0) begin
            c = ALIGN_SUBMULT;
         end
      end
      return c;
   endfunction

endpackage

// ---- rtl/role_sampler.sv ----
module role_sampler (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic role_select_pin_in,
   output logic role_master_out
);
   import redundancy_pkg::*;

   logic role_reg;

   // Master until the first sample, so nothing is forced during reset
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         role_reg <= 1'b1;
      end else if (ce_in) begin
         role_reg <= role_select_pin_in;
      end
   end

   assign role_master_out = role_reg;

endmodule // role_sampler

// ---- rtl/align_qualifier.sv ----
`include "redundancy_map.svh"

module align_qualifier (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic locked_in,
   input wire logic buildout_en_in,
   input wire logic [31:0] ratio_in,
   output redundancy_pkg::align_class_e [`N_OUT-1:0] class_out,
   output logic [`N_OUT-1:0] aligned_out
);
   import redundancy_pkg::*;

   align_class_e [`N_OUT-1:0] class_reg;
   logic [`N_OUT-1:0] aligned_reg;
   wire qualify = locked_in & ~buildout_en_in;

   genvar i;
   generate
      for (i = 0; i < `N_OUT; i++) begin : g_out
         wire align_class_e cls = classify(ratio_s'(ratio_in[8*i +: 8]));
         always_ff @(posedge core_clk_in) begin
            if (rst_in) begin
               class_reg[i] <= ALIGN_NONE;
               aligned_reg[i] <= 1'b0;
            end else if (ce_in) begin
               class_reg[i] <= cls;
               aligned_reg[i] <= qualify & (cls != ALIGN_NONE);
            end
         end
      end
   endgenerate

   assign class_out = class_reg;
   assign aligned_out = aligned_reg;

endmodule // align_qualifier

// ---- rtl/redundancy_control.sv ----
// Design decisions made here: the Avalon-MM interface to the registers and the register addresses.
`include "redundancy_map.svh"

module redundancy_control (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic role_select_pin_in,
   input wire logic main_locked_in,
   input wire logic aux_locked_in,
   input wire logic [7:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   output redundancy_pkg::loop_config_s main_config_out,
   output logic role_master_out,
   output redundancy_pkg::align_class_e [`N_OUT-1:0] main_class_out,
   output logic [`N_OUT-1:0] main_aligned_out,
   output redundancy_pkg::align_class_e [`N_OUT-1:0] aux_class_out,
   output logic [`N_OUT-1:0] aux_aligned_out
);
   import redundancy_pkg::*;

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
      return addr[7:2] == target[7:2];
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old_val, input logic [31:0] new_val,
                                         input logic [3:0] be);
      logic [31:0] m;
      m = old_val;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            m[8*b +: 8] = new_val[8*b +: 8];
         end
      end
      return m;
   endfunction

   // Software-written registers
   logic [7:0] pri_reg [`PRI_WORDS];
   logic revertive_switch_enable_reg;
   logic pbo_reg;
   logic mon_pbo_reg;
   logic [7:0] abw_reg;
   logic [7:0] lbw_reg;
   logic [31:0] ratio_main_reg;
   logic [31:0] ratio_aux_reg;

   // Bus slave state
   bus_state_e state_reg;
   bus_state_e state_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;

   // Effective configuration
   loop_config_s cfg_reg;
   loop_config_s cfg_next;

   wire logic role_master;
   wire logic request = avs_read_in | avs_write_in;
   wire logic answering = (state_reg == BUS_ANSWER) & ce_in;
   wire logic wr_fire = answering & avs_write_in;
   wire logic slave_role = ~role_master;

   wire logic [31:0] wmerged_lane0 = merge(32'h0, avs_writedata_in, avs_byteenable_in);
   wire logic [31:0] ratio_main_wr = merge(ratio_main_reg, avs_writedata_in, avs_byteenable_in);
   wire logic [31:0] ratio_aux_wr = merge(ratio_aux_reg, avs_writedata_in, avs_byteenable_in);
   wire logic lane0 = avs_byteenable_in[0];

   wire logic wr_main_control_three = wr_fire & lane0 & hit(avs_address_in, `REG_MAIN_CONTROL_THREE);
   wire logic wr_main_control_ten = wr_fire & lane0 & hit(avs_address_in, `REG_MAIN_CONTROL_TEN);
   wire logic wr_phase_monitor_reg = wr_fire & lane0 & hit(avs_address_in, `REG_PHASE_MONITOR_REG);
   wire logic wr_abw = wr_fire & lane0 & hit(avs_address_in, `REG_ABW);
   wire logic wr_lbw = wr_fire & lane0 & hit(avs_address_in, `REG_LBW);
   wire logic wr_rmain = wr_fire & hit(avs_address_in, `REG_RATIO_MAIN);
   wire logic wr_raux = wr_fire & hit(avs_address_in, `REG_RATIO_AUX);

   role_sampler u_role (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .role_select_pin_in(role_select_pin_in),
      .role_master_out(role_master)
   );

   // Request held until waitrequest is seen low; one answer cycle
   assign avs_waitrequest_out = request & ~answering;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         BUS_IDLE: begin
            if (request) begin
               state_next = BUS_ANSWER;
            end
         end
         BUS_ANSWER: begin
            state_next = BUS_IDLE;
         end
         default: begin
            state_next = BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         state_reg <= BUS_IDLE;
         rdata_reg <= 32'h0;
      end else if (ce_in) begin
         state_reg <= state_next;
         rdata_reg <= rdata_next;
      end
   end

   // Priority words
   genvar w;
   generate
      for (w = 0; w < `PRI_WORDS; w++) begin : g_pri
         wire logic wr_pri = wr_fire & lane0 & (avs_address_in[7:2] == 6'(w));
         always_ff @(posedge core_clk_in) begin
            if (rst_in) begin
               pri_reg[w] <= `PRI_RST;
            end else if (ce_in && wr_pri) begin
               pri_reg[w] <= wmerged_lane0[7:0];
            end
         end
      end
   endgenerate

   // Control registers; the role bit is not stored and ignores writes
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         revertive_switch_enable_reg <= `MAIN_CONTROL_THREE_RST;
         pbo_reg <= `MAIN_CONTROL_TEN_RST;
         mon_pbo_reg <= `PHASE_MONITOR_REG_RST;
         abw_reg <= `ABW_RST;
         lbw_reg <= `LBW_RST;
         ratio_main_reg <= `RATIO_RST;
         ratio_aux_reg <= `RATIO_RST;
      end else if (ce_in) begin
         if (wr_main_control_three) begin
            revertive_switch_enable_reg <= avs_writedata_in[`MAIN_CONTROL_THREE_REVERTIVE_SWITCH_ENABLE_BIT];
         end
         if (wr_main_control_ten) begin
            pbo_reg <= avs_writedata_in[`MAIN_CONTROL_TEN_PBO_BIT];
         end
         if (wr_phase_monitor_reg) begin
            mon_pbo_reg <= avs_writedata_in[`PHASE_MONITOR_REG_PBO_BIT];
         end
         if (wr_abw) begin
            abw_reg <= avs_writedata_in[7:0];
         end
         if (wr_lbw) begin
            lbw_reg <= avs_writedata_in[7:0];
         end
         if (wr_rmain) begin
            ratio_main_reg <= ratio_main_wr;
         end
         if (wr_raux) begin
            ratio_aux_reg <= ratio_aux_wr;
         end
      end
   end

   // Forced slave settings; the master takes software values unchanged
   always_comb begin
      cfg_next = '0;
      for (int k = 0; k < `PRI_WORDS; k++) begin
         cfg_next.prio[2*k] = pri_reg[k][3:0];
         cfg_next.prio[2*k+1] = pri_reg[k][7:4];
      end
      cfg_next.buildout_en = pbo_reg;
      cfg_next.monitor_buildout_en = mon_pbo_reg;
      cfg_next.revertive_en = revertive_switch_enable_reg;
      cfg_next.bandwidth = main_locked_in ? lbw_reg : abw_reg;
      if (slave_role) begin
         cfg_next.prio[2*`PARTNER_WORD] = `FORCED_PRIORITY;
         cfg_next.buildout_en = 1'b0;
         cfg_next.revertive_en = 1'b1;
         cfg_next.bandwidth = abw_reg;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         cfg_reg <= '0;
      end else if (ce_in) begin
         cfg_reg <= cfg_next;
      end
   end

   assign main_config_out = cfg_reg;
   assign role_master_out = role_master;

   align_qualifier u_main_align (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .locked_in(main_locked_in),
      .buildout_en_in(cfg_reg.buildout_en),
      .ratio_in(ratio_main_reg),
      .class_out(main_class_out),
      .aligned_out(main_aligned_out)
   );

   // Auxiliary outputs follow the same alignment behaviour
   align_qualifier u_aux_align (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .locked_in(aux_locked_in),
      .buildout_en_in(cfg_reg.buildout_en),
      .ratio_in(ratio_aux_reg),
      .class_out(aux_class_out),
      .aligned_out(aux_aligned_out)
   );

   // Read mux; shows stored values, status shows effective values
   wire logic [5:0] ridx = avs_address_in[7:2];
   wire logic [31:0] status_word = {16'h0, aux_aligned_out, main_aligned_out,
                                    3'h0, aux_locked_in, main_locked_in,
                                    cfg_reg.revertive_en, cfg_reg.buildout_en, role_master};
   wire logic [31:0] main_control_three_word = {30'h0, role_master, revertive_switch_enable_reg};

   always_comb begin
      rdata_next = rdata_reg;
      if (state_reg == BUS_IDLE && avs_read_in) begin
         rdata_next = 32'h0;
         if (ridx < 6'(`PRI_WORDS)) begin
            rdata_next = {24'h0, pri_reg[ridx[2:0]]};
         end else if (hit(avs_address_in, `REG_MAIN_CONTROL_THREE)) begin
            rdata_next = main_control_three_word;
         end else if (hit(avs_address_in, `REG_MAIN_CONTROL_TEN)) begin
            rdata_next = {31'h0, pbo_reg};
         end else if (hit(avs_address_in, `REG_PHASE_MONITOR_REG)) begin
            rdata_next = {31'h0, mon_pbo_reg};
         end else if (hit(avs_address_in, `REG_ABW)) begin
            rdata_next = {24'h0, abw_reg};
         end else if (hit(avs_address_in, `REG_LBW)) begin
            rdata_next = {24'h0, lbw_reg};
         end else if (hit(avs_address_in, `REG_STATUS)) begin
            rdata_next = status_word;
         end else if (hit(avs_address_in, `REG_RATIO_MAIN)) begin
            rdata_next = ratio_main_reg;
         end else if (hit(avs_address_in, `REG_RATIO_AUX)) begin
            rdata_next = ratio_aux_reg;
         end
      end
   end

   assign avs_readdata_out = rdata_reg;

endmodule // redundancy_control

// ---- verification/redundancy_control_chk.sv ----
module redundancy_control_chk (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic role_select_pin_in,
   input wire logic main_locked_in,
   input wire logic aux_locked_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic avs_waitrequest_out,
   input wire redundancy_pkg::loop_config_s main_config_out,
   input wire logic role_master_out,
   input wire logic [3:0] main_aligned_out,
   input wire logic [3:0] aux_aligned_out
);
   timeunit 1ns;
   timeprecision 1ps;
   import redundancy_pkg::*;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   chk_slave_prio: assert property (!role_master_out && ce_in |=> main_config_out.prio[10] == 4'h1)
      else $error("slave partner priority not forced");
   chk_slave_buildout: assert property (!role_master_out && ce_in |=> !main_config_out.buildout_en)
      else $error("slave build-out not forced off");
   chk_slave_revertive: assert property (!role_master_out && ce_in |=> main_config_out.revertive_en)
      else $error("slave revertive not forced on");
   chk_slave_bw_fixed: assert property (!role_master_out && !$past(role_master_out) && !avs_write_in
      && !$past(avs_write_in) && ce_in |=> $stable(main_config_out.bandwidth))
      else $error("slave bandwidth moved with lock");
   chk_role_follow: assert property (ce_in |=> role_master_out == $past(role_select_pin_in))
      else $error("role status does not follow pin");
   chk_bus_answer: assert property ((avs_read_in || avs_write_in) && ce_in |-> ##[0:1] !avs_waitrequest_out)
      else $error("bus request not answered in one cycle");
   chk_main_unlocked: assert property (!main_locked_in && ce_in |=> main_aligned_out == 4'h0)
      else $error("main output aligned while unlocked");
   chk_aux_unlocked: assert property (!aux_locked_in && ce_in |=> aux_aligned_out == 4'h0)
      else $error("aux output aligned while unlocked");
endmodule // redundancy_control_chk

bind redundancy_control redundancy_control_chk chk_u (.core_clk_in, .rst_in, .ce_in,
   .role_select_pin_in, .main_locked_in, .aux_locked_in, .avs_read_in, .avs_write_in,
   .avs_waitrequest_out, .main_config_out, .role_master_out, .main_aligned_out, .aux_aligned_out);

// ---- verification/partner_device.sv ----
module partner_device (
   input wire logic core_clk_in,
   input wire logic partner_master_in,
   input wire logic feature_off_in,
   input wire logic ref_valid_in,
   output logic role_select_pin_out,
   output logic main_locked_out,
   output logic aux_locked_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] lock_cnt_reg;
   // Opposite straps, or both high when the role feature is off
   assign role_select_pin_out = feature_off_in | !partner_master_in;
   // Cross-wired partner clock: our loops lock a few cycles after it turns valid
   always @(posedge core_clk_in) begin
      if (!ref_valid_in) lock_cnt_reg <= 3'h0;
      else if (lock_cnt_reg != 3'h7) lock_cnt_reg <= lock_cnt_reg + 3'h1;
   end
   assign main_locked_out = (lock_cnt_reg == 3'h7);
   // Auxiliary path locks together with the main path, to the partner clock
   assign aux_locked_out = main_locked_out;
endmodule // partner_device

// ---- verification/tb_master_slave_redundancy_control.sv ----
`include "redundancy_map.svh"
module tb_master_slave_redundancy_control;
   timeunit 1ns;
   timeprecision 1ps;
   import redundancy_pkg::*;
   localparam logic [7:0] mode_addr = 8'h1c;
   localparam logic [7:0] buildout_addr = 8'h20;
   localparam logic [7:0] mon_addr = 8'h24;
   logic core_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic partner_master = 1'b0;
   logic ref_valid = 1'b0;
   logic feature_off = 1'b0;
   logic ce_in = 1'b1;
   logic role_pin, main_locked, aux_locked, avs_waitrequest_out, role_master_out;
   logic [7:0] avs_address_in = 8'h00;
   logic avs_read_in = 1'b0;
   logic avs_write_in = 1'b0;
   logic [31:0] avs_writedata_in = 32'h0;
   logic [3:0] avs_byteenable_in = 4'hf;
   logic [31:0] avs_readdata_out, rd;
   loop_config_s main_config_out;
   align_class_e [`N_OUT-1:0] main_class_out, aux_class_out;
   logic [`N_OUT-1:0] main_aligned_out, aux_aligned_out;
   int miscompares = 0;
   int comparisons = 0;

   always #20 core_clk_in = ~core_clk_in;

   partner_device partner_u (.core_clk_in(core_clk_in), .partner_master_in(partner_master),
      .feature_off_in(feature_off), .ref_valid_in(ref_valid), .role_select_pin_out(role_pin),
      .main_locked_out(main_locked), .aux_locked_out(aux_locked));

   redundancy_control dut_u (.core_clk_in(core_clk_in), .rst_in(rst_in), .ce_in(ce_in),
      .role_select_pin_in(role_pin), .main_locked_in(main_locked), .aux_locked_in(aux_locked),
      .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
      .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
      .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
      .main_config_out(main_config_out), .role_master_out(role_master_out),
      .main_class_out(main_class_out), .main_aligned_out(main_aligned_out),
      .aux_class_out(aux_class_out), .aux_aligned_out(aux_aligned_out));

   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Waits for the answer as long as it takes; only the watchdog ends a hang
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_in);
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_write_in <= wr;
      avs_read_in <= !wr;
      do begin
         @(posedge core_clk_in);
      end while (avs_waitrequest_out !== 1'b0);
      rd = avs_readdata_out;
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
   endtask

   task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      cmp(what, exp, rd);
   endtask

   task automatic wait_clk(input int n);
      repeat (n) @(posedge core_clk_in);
   endtask

   task automatic t_reset_values;
      rdc("priority word", `REG_PRI_BASE, 32'h0);
      rdc("mode reg", mode_addr, 32'h2);
      rdc("buildout reg", buildout_addr, 32'h1);
      rdc("monitor reg", mon_addr, 32'h1);
      rdc("acq bandwidth", `REG_ABW, 32'h10);
      rdc("lock bandwidth", `REG_LBW, 32'h4);
      rdc("main ratio", `REG_RATIO_MAIN, 32'h11111111);
      rdc("unmapped", 8'h3c, 32'h0);
   endtask

   task automatic t_master;
      bus(1'b1, `REG_PRI_BASE + 8'h14, 32'h30);
      wait_clk(3);
      cmp("partner prio", 32'h0, main_config_out.prio[10]);
      cmp("next prio", 32'h3, main_config_out.prio[11]);
      cmp("buildout", 32'h1, main_config_out.buildout_en);
      cmp("revertive", 32'h0, main_config_out.revertive_en);
      cmp("bw unlocked", 32'h10, main_config_out.bandwidth);
      ref_valid <= 1'b1;
      wait_clk(12);
      cmp("bw locked", 32'h04, main_config_out.bandwidth);
   endtask

   task automatic t_slave;
      partner_master <= 1'b1;
      wait_clk(3);
      cmp("slave prio", 32'h1, main_config_out.prio[10]);
      cmp("slave buildout", 32'h0, main_config_out.buildout_en);
      cmp("slave revertive", 32'h1, main_config_out.revertive_en);
      cmp("slave bw", 32'h10, main_config_out.bandwidth);
      bus(1'b1, `REG_ABW, 32'h46);
      rdc("status", `REG_STATUS, 32'h0000ff1c);
      cmp("slave bw high", 32'h46, main_config_out.bandwidth);
      bus(1'b1, mode_addr, 32'h2);
      rdc("mode reg", mode_addr, 32'h0);
      rdc("buildout stored", buildout_addr, 32'h1);
      bus(1'b1, mon_addr, 32'h0);
      rdc("monitor stored", mon_addr, 32'h0);
      partner_master <= 1'b0;
      wait_clk(3);
      cmp("master prio", 32'h0, main_config_out.prio[10]);
      cmp("master buildout", 32'h1, main_config_out.buildout_en);
      cmp("master monitor", 32'h0, main_config_out.monitor_buildout_en);
      feature_off <= 1'b1;
      partner_master <= 1'b1;
      wait_clk(3);
      cmp("feature off role", 32'h1, role_master_out);
      cmp("feature off prio", 32'h0, main_config_out.prio[10]);
      feature_off <= 1'b0;
      partner_master <= 1'b0;
   endtask

   task automatic t_align;
      bus(1'b1, buildout_addr, 32'h0);
      bus(1'b1, `REG_RATIO_MAIN, 32'h23122111);
      bus(1'b1, `REG_RATIO_AUX, 32'h23122111);
      wait_clk(4);
      cmp("main class", 32'he4, main_class_out);
      cmp("main aligned", 32'h7, main_aligned_out);
      cmp("aux class", 32'he4, aux_class_out);
      cmp("aux aligned", 32'h7, aux_aligned_out);
      ref_valid <= 1'b0;
      wait_clk(3);
      cmp("main unlocked", 32'h0, main_aligned_out);
      avs_byteenable_in <= 4'h8;
      bus(1'b1, `REG_RATIO_AUX, 32'h11000000);
      bus(1'b1, `REG_ABW, 32'h55);
      avs_byteenable_in <= 4'hf;
      rdc("aux ratio lane", `REG_RATIO_AUX, 32'h11122111);
      rdc("abw lane", `REG_ABW, 32'h46);
   endtask

   // Clock enable low must hold the sampled role and the configuration
   task automatic t_freeze;
      ce_in <= 1'b0;
      partner_master <= 1'b1;
      wait_clk(4);
      cmp("frozen role", 32'h1, role_master_out);
      cmp("frozen prio", 32'h0, main_config_out.prio[10]);
      ce_in <= 1'b1;
      wait_clk(3);
      cmp("thawed role", 32'h0, role_master_out);
      cmp("thawed prio", 32'h1, main_config_out.prio[10]);
      partner_master <= 1'b0;
      wait_clk(3);
   endtask

   task automatic report_and_stop;
      if (miscompares == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      wait_clk(12);
      rst_in <= 1'b0;
      t_reset_values;
      t_master;
      t_slave;
      t_align;
      t_freeze;
      report_and_stop;
   end

   initial begin
      wait_clk(5000);
      miscompares++;
      report_and_stop;
   end
endmodule // tb_master_slave_redundancy_control
